// ---- rtl/dfr_pkg.sv ----
// Constants shared by the disturbance and fault recorder controller.
// Assumes a 250 MHz pclk and a 50 Hz power system.
package dfr_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_HZ = 250_000_000;
    localparam int MAINS_HZ = 50;
    localparam int SMP_PER_CYCLE = 32;
    localparam int SMP_HZ = MAINS_HZ * SMP_PER_CYCLE;
    localparam int TICK_CYC = CLK_HZ / SMP_HZ;
    localparam int LEN_MAX_S = 15;
    localparam int STORE_S = 120;
    localparam logic [14:0] LEN_MAX_SMP = 15'(LEN_MAX_S * SMP_HZ);
    localparam logic [17:0] STORE_SMP = 18'(STORE_S * SMP_HZ);
    localparam int N_TRIG = 8;
    localparam int FAULT_DEPTH = 20;
    localparam logic [6:0] PCT_FULL = 7'h64;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LIMIT = 8'h04;
    localparam logic [7:0] OFS_PCT = 8'h08;
    localparam logic [7:0] OFS_TSEL = 8'h0c;
    localparam logic [7:0] OFS_MDLY = 8'h10;
    localparam logic [7:0] OFS_DSTAT = 8'h14;
    localparam logic [7:0] OFS_DSTORE = 8'h18;
    localparam logic [7:0] OFS_DFIRST = 8'h1c;
    localparam logic [7:0] OFS_FSTAT = 8'h20;
    localparam logic [7:0] OFS_FSEL = 8'h24;
    localparam logic [7:0] OFS_FDUR = 8'h28;
    localparam logic [7:0] OFS_FTTT = 8'h2c;
    localparam logic [7:0] OFS_FMEAS = 8'h30;
    localparam logic [7:0] OFS_FINFO = 8'h34;
    localparam logic [7:0] OFS_DTIME = 8'h38;
    // ==========================================================
    // Field positions
    localparam int CTRL_OW_BIT = 0;
    localparam int CTRL_MODE_BIT = 1;
    localparam int CTRL_EN_BIT = 2;
    localparam int CTRL_CLR_BIT = 3;
    localparam int PCT_LEAD_LSB = 0;
    localparam int PCT_TAIL_LSB = 8;
    localparam int FSTAT_NOTIFY_BIT = 31;
    localparam int FTTT_OK_BIT = 31;
    // ==========================================================
    // Reset values
    localparam logic [2:0] CTRL_RST = 3'h4;
    localparam logic [14:0] LIMIT_RST = 15'h0c80;
    localparam logic [6:0] LEAD_PCT_RST = 7'h14;
    localparam logic [6:0] TAIL_PCT_RST = 7'h14;
    localparam logic [7:0] TSEL_RST = 8'h01;
    localparam logic [15:0] MDLY_RST = 16'h0000;
endpackage

// ---- rtl/dfr_tick_div.sv ----
// Sample tick divider: one-cycle enable every DIV clocks.
// Assumes a single free-running clock and an asynchronous low reset.
module dfr_tick_div #(
    parameter int DIV = 156250
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    localparam int CW = $clog2(DIV);

    if (DIV < 2) begin : g_chk
        $error("dfr_tick_div: DIV must be at least 2");
    end

    logic [CW-1:0] cnt_q;
    wire last = (cnt_q == CW'(DIV - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else begin
            cnt_q <= last ? '0 : cnt_q + 1'b1;
            tick <= last;
        end
    end
endmodule

// ---- rtl/dfr_ctrl.sv ----
// Disturbance and fault recorder controller with APB register access.
// Assumes trigger, pickup, trip and measurement inputs come from logic on pclk.
// Summary of operation
// - Record length limited, at most 15 s
// - Lead-in and tail are percentages of limit
// - Eight selectable triggers, OR starts record
// - Re-arm only after causing triggers drop
// - Record always holds full lead-in history
// - Event portion: trigger time, capped by limit
// - Tail: configured, capped by remaining length
// - Recording stops when length limit elapses
// - Full storage: overwrite oldest or stop
// - Fault record starts on pickup rising edge
// - Fault duration spans the general pickup
// - Time-to-trip: first pickup to first trip
// - General trip is OR of trips
// - Measurements captured at trip, optionally delayed
// - Mode selects alarms-and-trips or trips only
// - Notification on pickup fall, newest record
// - Time-to-trip invalid across different modules
// - Twenty fault records, oldest overwritten
// - Newest record handed to non-volatile store
// - Each record flags whether it tripped
// - Channels sampled 32 times per cycle
// - Shared storage of 120 s
// - Fault number increments per general pickup
module dfr_ctrl import dfr_pkg::*; #(
    parameter int TICK_CYCLES = TICK_CYC,
    parameter int MODS = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [N_TRIG-1:0] trig_in,
    input wire logic [MODS-1:0] pickup_in,
    input wire logic [MODS-1:0] trip_in,
    input wire logic [31:0] meas_in,
    output logic smp_we,
    output logic [17:0] smp_addr,
    output logic rec_start,
    output logic rec_done,
    output logic [17:0] rec_first_addr,
    output logic fault_notify,
    output logic nv_we,
    output logic [31:0] nv_meas,
    output logic [23:0] nv_dur,
    output logic [23:0] nv_info
);
    if (MODS < 1 || MODS > 8) begin : g_chk
        $error("dfr_ctrl: MODS must be 1 to 8");
    end

    typedef enum logic [1:0] {DS_IDLE, DS_EVENT, DS_TAIL} dfr_dstate_t;

    function automatic logic [2:0] first_set(input logic [MODS-1:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = MODS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // ==========================================================
    // Sample tick
    logic tick;
    dfr_tick_div #(.DIV(TICK_CYCLES)) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    // ==========================================================
    // APB register access
    logic [2:0] ctrl_q;
    logic [14:0] limit_q;
    logic [6:0] lead_pct_q, tail_pct_q;
    logic [7:0] tsel_q;
    logic [15:0] mdly_q;
    logic [4:0] fsel_q;
    logic [31:0] rd_mux;
    logic notify_q;

    wire setup = psel & ~penable;
    wire wr = psel & penable & pwrite;
    wire auto_ow = ctrl_q[CTRL_OW_BIT];
    wire mode_all = ctrl_q[CTRL_MODE_BIT];
    wire dist_en = ctrl_q[CTRL_EN_BIT];
    wire wr_ctrl = wr & (paddr == OFS_CTRL);
    wire wr_limit = wr & (paddr == OFS_LIMIT);
    wire wr_pct = wr & (paddr == OFS_PCT);
    wire clr_store = wr_ctrl & pwdata[CTRL_CLR_BIT];
    wire clr_notify = wr & (paddr == OFS_FSTAT) & pwdata[FSTAT_NOTIFY_BIT];
    wire cfg_wr = wr_limit | wr_pct;
    wire mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_DTIME);
    wire [14:0] limit_in = (pwdata > 32'(LEN_MAX_SMP)) ? LEN_MAX_SMP :
                           (pwdata[14:0] == 15'h0) ? 15'h0001 : pwdata[14:0];
    wire [6:0] lead_in_p = pwdata[PCT_LEAD_LSB +: 7];
    wire [6:0] tail_in_p = pwdata[PCT_TAIL_LSB +: 7];

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign fault_notify = notify_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            limit_q <= LIMIT_RST;
            lead_pct_q <= LEAD_PCT_RST;
            tail_pct_q <= TAIL_PCT_RST;
            tsel_q <= TSEL_RST;
            mdly_q <= MDLY_RST;
            fsel_q <= 5'h00;
            prdata <= 32'h0000_0000;
        end else begin
            if (setup) prdata <= mapped ? rd_mux : 32'h0000_0000;
            if (wr_ctrl) ctrl_q <= pwdata[2:0];
            if (wr_limit) limit_q <= limit_in;
            if (wr_pct) begin
                lead_pct_q <= (lead_in_p > PCT_FULL) ? PCT_FULL : lead_in_p;
                tail_pct_q <= (tail_in_p > PCT_FULL) ? PCT_FULL : tail_in_p;
            end
            if (wr & (paddr == OFS_TSEL)) tsel_q <= pwdata[7:0];
            if (wr & (paddr == OFS_MDLY)) mdly_q <= pwdata[15:0];
            if (wr & (paddr == OFS_FSEL)) begin
                fsel_q <= (pwdata > 32'(FAULT_DEPTH - 1)) ? 5'(FAULT_DEPTH - 1) : pwdata[4:0];
            end
        end
    end

    // ==========================================================
    // Disturbance recorder
    dfr_dstate_t st_q;
    logic [14:0] win_q, hist_q, rec_cnt_q, event_portion, tail_actual;
    logic [14:0] lim_r_q, lead_r_q, tail_r_q;
    logic [17:0] base_q, used_q;
    logic [7:0] cause_q, tprev_q, nrec_q;
    logic ovw_q;

    wire [21:0] lead_prod = 22'(limit_q) * 22'(lead_pct_q);
    wire [21:0] tail_prod = 22'(limit_q) * 22'(tail_pct_q);
    wire [14:0] lead_in_duration = 15'(lead_prod / 22'd100);
    wire [14:0] tail_duration = 15'(tail_prod / 22'd100);
    wire [14:0] length_limit = limit_q;
    wire [7:0] trig_act = trig_in & tsel_q;
    wire trig_or = |trig_act;
    wire trig_rise = |(trig_act & ~tprev_q);
    wire rearm = ((trig_in & cause_q) == 8'h00);
    wire full = ({1'b0, used_q} + 19'(length_limit)) > 19'(STORE_SMP);
    wire can_store = ~full | auto_ow;
    wire hist_ok = hist_q >= lead_in_duration;
    wire idle = (st_q == DS_IDLE);
    wire start = idle & dist_en & trig_rise & rearm & hist_ok & can_store;
    wire [14:0] win_lim = idle ? length_limit : lim_r_q;
    wire [14:0] win_nx = (win_q + 15'h1 == win_lim) ? 15'h0 : win_q + 15'h1;
    wire [18:0] addr_sum = {1'b0, base_q} + 19'(win_q);
    wire [14:0] first_ofs = (win_q >= lead_in_duration) ? win_q - lead_in_duration :
                            win_q + length_limit - lead_in_duration;
    wire [18:0] first_sum = {1'b0, base_q} + 19'(first_ofs);
    wire [18:0] base_sum = {1'b0, base_q} + 19'(lim_r_q);
    wire [18:0] used_sum = {1'b0, used_q} + 19'(lim_r_q);
    wire last_smp = (rec_cnt_q + 15'h1 == lim_r_q);
    wire ev_cap = (event_portion + 15'h1 >= lim_r_q - lead_r_q);
    wire tail_end = (tail_actual + 15'h1 >= tail_r_q);
    wire ev_tick = (st_q == DS_EVENT) & tick & trig_or;
    wire tl_tick = (st_q == DS_TAIL) & tick;
    wire ev_off = (st_q == DS_EVENT) & ~trig_or;
    wire finish = (ev_tick & (last_smp | ev_cap)) |
                  (ev_off & (tail_r_q == 15'h0)) |
                  (tl_tick & (last_smp | tail_end));

    assign smp_we = tick & (~idle | (dist_en & can_store));
    assign smp_addr = (addr_sum >= 19'(STORE_SMP)) ? 18'(addr_sum - 19'(STORE_SMP)) :
                      addr_sum[17:0];
    assign rec_start = start;
    assign rec_done = finish;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= DS_IDLE;
            {win_q, hist_q, rec_cnt_q, event_portion, tail_actual} <= '0;
            {lim_r_q, lead_r_q, tail_r_q} <= '0;
            {base_q, used_q, rec_first_addr} <= '0;
            {cause_q, tprev_q, nrec_q} <= '0;
            ovw_q <= 1'b0;
        end else begin
            tprev_q <= trig_act;
            if (smp_we) win_q <= win_nx;
            if (cfg_wr & idle) begin
                win_q <= 15'h0;
                hist_q <= 15'h0;
            end else if (smp_we & idle & (hist_q != length_limit)) begin
                hist_q <= hist_q + 15'h1;
            end
            if (clr_store) begin
                used_q <= 18'h0;
                nrec_q <= 8'h0;
                ovw_q <= 1'b0;
            end
            if (rearm) cause_q <= 8'h00;
            if (start) begin
                st_q <= DS_EVENT;
                lim_r_q <= length_limit;
                lead_r_q <= lead_in_duration;
                tail_r_q <= tail_duration;
                cause_q <= trig_act;
                rec_cnt_q <= lead_in_duration;
                event_portion <= 15'h0;
                tail_actual <= 15'h0;
                rec_first_addr <= (first_sum >= 19'(STORE_SMP)) ?
                                  18'(first_sum - 19'(STORE_SMP)) : first_sum[17:0];
                if (full) ovw_q <= 1'b1;
            end
            if (ev_tick | tl_tick) rec_cnt_q <= rec_cnt_q + 15'h1;
            if (ev_tick) event_portion <= event_portion + 15'h1;
            if (tl_tick) tail_actual <= tail_actual + 15'h1;
            if (ev_off) st_q <= DS_TAIL;
            if (finish) begin
                st_q <= DS_IDLE;
                win_q <= 15'h0;
                hist_q <= 15'h0;
                base_q <= (base_sum >= 19'(STORE_SMP)) ? 18'(base_sum - 19'(STORE_SMP)) :
                          base_sum[17:0];
                used_q <= (used_sum > 19'(STORE_SMP)) ? STORE_SMP : used_sum[17:0];
                nrec_q <= (nrec_q == 8'hff) ? nrec_q : nrec_q + 8'h1;
            end
        end
    end

    // ==========================================================
    // Fault recorder
    logic gp_q, fact_q, tripped_q, ftt_ok_q, mpend_q;
    logic [23:0] fdur_q, ftt_q;
    logic [2:0] pu_mod_q, tr_mod_q;
    logic [15:0] mcnt_q, fno_q;
    logic [31:0] meas_q;
    logic [4:0] wptr_q, fcnt_q;
    logic [23:0] fr_dur [FAULT_DEPTH];
    logic [24:0] fr_ttt [FAULT_DEPTH];
    logic [31:0] fr_meas [FAULT_DEPTH];
    logic [23:0] fr_info [FAULT_DEPTH];

    wire gp = |pickup_in;
    wire gt = |trip_in;
    wire gp_rise = gp & ~gp_q;
    wire gp_fall = ~gp & gp_q;
    wire first_trip = fact_q & gt & ~tripped_q;
    wire [2:0] trip_mod = first_set(trip_in);
    wire meas_now = first_trip & (mdly_q == 16'h0);
    wire meas_late = mpend_q & tick & (mcnt_q == 16'h1);
    wire [31:0] meas_fin = mpend_q ? meas_in : meas_q;
    wire store = gp_fall & (tripped_q | mode_all);
    wire [23:0] info_fin = {fno_q, tripped_q, ftt_ok_q, pu_mod_q, tr_mod_q};
    wire [4:0] wptr_nx = (wptr_q == 5'(FAULT_DEPTH - 1)) ? 5'h0 : wptr_q + 5'h1;
    wire [5:0] rd_raw = {1'b0, wptr_q} + 6'(FAULT_DEPTH - 1) - {1'b0, fsel_q};
    wire [4:0] rd_idx = (rd_raw >= 6'(FAULT_DEPTH)) ? 5'(rd_raw - 6'(FAULT_DEPTH)) :
                        rd_raw[4:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {gp_q, fact_q, tripped_q, ftt_ok_q, mpend_q, notify_q, nv_we} <= '0;
            {fdur_q, ftt_q} <= '0;
            {pu_mod_q, tr_mod_q, mcnt_q, fno_q, meas_q} <= '0;
            {wptr_q, fcnt_q} <= '0;
            {nv_meas, nv_dur, nv_info} <= '0;
        end else begin
            gp_q <= gp;
            nv_we <= store;
            if (gp_rise) begin
                fact_q <= 1'b1;
                fno_q <= fno_q + 16'h1;
                {fdur_q, ftt_q} <= '0;
                {tripped_q, ftt_ok_q, mpend_q} <= '0;
                pu_mod_q <= first_set(pickup_in);
                meas_q <= 32'h0;
            end else if (fact_q & tick) begin
                fdur_q <= fdur_q + 24'h1;
                if (!tripped_q) ftt_q <= ftt_q + 24'h1;
            end
            if (first_trip) begin
                tripped_q <= 1'b1;
                tr_mod_q <= trip_mod;
                ftt_ok_q <= (trip_mod == pu_mod_q);
                mpend_q <= (mdly_q != 16'h0);
                mcnt_q <= mdly_q;
            end
            if (meas_now | meas_late) meas_q <= meas_in;
            if (mpend_q & tick) mcnt_q <= mcnt_q - 16'h1;
            if (meas_late) mpend_q <= 1'b0;
            if (gp_fall) begin
                fact_q <= 1'b0;
                mpend_q <= 1'b0;
                meas_q <= meas_fin;
            end
            if (store) begin
                wptr_q <= wptr_nx;
                if (fcnt_q != 5'(FAULT_DEPTH)) fcnt_q <= fcnt_q + 5'h1;
                nv_meas <= meas_fin;
                nv_dur <= fdur_q;
                nv_info <= info_fin;
            end
            // Set wins over a software clear in the same cycle
            if (gp_fall) notify_q <= 1'b1;
            else if (clr_notify) notify_q <= 1'b0;
        end
    end

    // Record memory: no reset, fsel clamp stops at FAULT_DEPTH - 1 so unwritten slots can be selected
    always_ff @(posedge pclk) begin
        if (store) begin
            fr_dur[wptr_q] <= fdur_q;
            fr_ttt[wptr_q] <= {ftt_ok_q & tripped_q, ftt_q};
            fr_meas[wptr_q] <= meas_fin;
            fr_info[wptr_q] <= info_fin;
        end
    end

    // ==========================================================
    // Read mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            OFS_CTRL: rd_mux = {29'h0, ctrl_q};
            OFS_LIMIT: rd_mux = {17'h0, limit_q};
            OFS_PCT: rd_mux = {17'h0, tail_pct_q, 1'b0, lead_pct_q};
            OFS_TSEL: rd_mux = {24'h0, tsel_q};
            OFS_MDLY: rd_mux = {16'h0, mdly_q};
            OFS_DSTAT: rd_mux = {20'h0, nrec_q, ovw_q, full, st_q};
            OFS_DSTORE: rd_mux = {14'h0, used_q};
            OFS_DFIRST: rd_mux = {14'h0, rec_first_addr};
            OFS_FSTAT: rd_mux = {notify_q, 10'h0, fcnt_q, fno_q};
            OFS_FSEL: rd_mux = {27'h0, fsel_q};
            OFS_FDUR: rd_mux = {8'h0, fr_dur[rd_idx]};
            OFS_FTTT: rd_mux = {fr_ttt[rd_idx][24], 7'h0, fr_ttt[rd_idx][23:0]};
            OFS_FMEAS: rd_mux = fr_meas[rd_idx];
            OFS_FINFO: rd_mux = {8'h0, fr_info[rd_idx]};
            OFS_DTIME: rd_mux = {1'b0, tail_actual, 1'b0, event_portion};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_len_bound: assert property (!idle |-> rec_cnt_q < lim_r_q)
        else $error("record ran past its length limit");
    chk_trig_start: assert property (start |=> st_q == DS_EVENT && rec_cnt_q == lead_r_q)
        else $error("trigger did not start a record with lead-in");
    chk_rearm_block: assert property (idle && !rearm |=> idle)
        else $error("record started before causing triggers dropped");
    chk_full_stop: assert property (idle && full && !auto_ow |=> idle)
        else $error("record started with storage full");
    chk_event_cap: assert property (!idle |-> event_portion + lead_r_q <= lim_r_q)
        else $error("event portion exceeds limit minus lead-in");
    chk_tail_cap: assert property (!idle |-> tail_actual <= tail_r_q)
        else $error("tail exceeds configured duration");
    chk_fault_no: assert property (gp_rise |=> fno_q == $past(fno_q) + 16'h1)
        else $error("fault number did not advance on pickup");
    chk_notify_set: assert property (gp_fall |=>
        notify_q && nv_we == $past(tripped_q | mode_all))
        else $error("pickup fall raised no notification");
    chk_trips_only: assert property (gp_fall && !mode_all && !tripped_q |=> $stable(wptr_q))
        else $error("untripped fault stored in trips-only mode");
    chk_fifo_cap: assert property (fcnt_q <= 5'(FAULT_DEPTH) && wptr_q < 5'(FAULT_DEPTH))
        else $error("fault record count out of range");
    chk_ttt_module: assert property (first_trip && trip_mod != pu_mod_q |=> !ftt_ok_q)
        else $error("time-to-trip valid across modules");
endmodule

// ---- verif/dfr_prot_model.sv ----
// Behavioural model of the protection stages that feed the recorder.
// Assumes the bench sets pickup and trip requests just after a pclk edge.
module dfr_prot_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] pu_req,
    input wire logic [7:0] tr_req,
    output logic [7:0] pickup,
    output logic [7:0] trip
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Stage outputs, registered like real protection logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pickup <= 8'h00;
            trip <= 8'h00;
        end else begin
            pickup <= pu_req;
            // A stage can only trip while it is picked up
            trip <= tr_req & pu_req;
        end
    end
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the recorder controller over APB.
// Assumes dfr_pkg is compiled first and a shortened sample tick of 8 clocks.
module testbench import dfr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, hit;
    logic smp_we, rec_start, rec_done, fault_notify, nv_we;
    logic [7:0] paddr, trig_in, pu_req, tr_req, pickup_in, trip_in;
    logic [31:0] pwdata, prdata, meas_in, nv_meas, rd;
    logic [17:0] smp_addr, rec_first_addr;
    logic [23:0] nv_dur, nv_info;
    int n_fail, checked, cyc, n;
    // ==========================================================
    // Design and far-side model
    dfr_ctrl #(.TICK_CYCLES(8), .MODS(8)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .trig_in, .pickup_in, .trip_in, .meas_in,
        .smp_we, .smp_addr, .rec_start, .rec_done, .rec_first_addr, .fault_notify, .nv_we,
        .nv_meas, .nv_dur, .nv_info);
    dfr_prot_model u_prot (.pclk, .presetn, .pu_req, .tr_req, .pickup(pickup_in),
        .trip(trip_in));
    // ==========================================================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
            input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd & m);
    endtask
    // Polls one pulse: 0 start, 1 done, else store strobe
    task automatic waitc(input int s, input int lim);
        n = 0;
        hit = 1'b0;
        while (!hit && n < lim) begin
            @(posedge pclk);
            n++;
            hit = ((s == 0) ? rec_start : (s == 1) ? rec_done : nv_we) === 1'b1;
        end
    endtask
    task automatic fault(input int pm, input int tm, input bit trp);
        pu_req <= 8'h01 << pm;
        repeat (30) @(posedge pclk);
        if (trp) begin
            pu_req <= pu_req | (8'h01 << tm);
            tr_req <= 8'h01 << tm;
            meas_in <= 32'h00c0ffee;
        end
        repeat (30) @(posedge pclk);
        meas_in <= 32'h0000beef;
        repeat (30) @(posedge pclk);
        pu_req <= 8'h00;
        tr_req <= 8'h00;
        waitc(2, 10);
    endtask
    task end_sim;
        if (n_fail == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // Clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            end_sim;
        end
    end
    // ==========================================================
    // Test sequence
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 8'h00;
        {pwdata, meas_in} = 64'h0;
        {trig_in, pu_req, tr_req} = 24'h0;
        {n_fail, checked, cyc} = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("ctrl", OFS_CTRL, 32'hf, 32'h4);
        rdchk("limit", OFS_LIMIT, 32'h7fff, 32'hc80);
        rdchk("pct", OFS_PCT, 32'h7f7f, 32'h1414);
        rdchk("tsel", OFS_TSEL, 32'hff, 32'h1);
        apb(1'b0, 8'h3c, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, OFS_LIMIT, 32'h7fff);
        rdchk("limit clamp", OFS_LIMIT, 32'h7fff, 32'h5dc0);
        apb(1'b1, OFS_LIMIT, 32'd20);
        apb(1'b1, OFS_PCT, 32'h3232);
        repeat (100) @(posedge pclk);
        trig_in <= 8'h02;
        waitc(0, 200);
        chk("unselected start", 32'h0, {31'h0, hit});
        trig_in <= 8'h00;
        apb(1'b1, OFS_TSEL, 32'h6);
        repeat (120) @(posedge pclk);
        trig_in <= 8'h04;
        waitc(0, 4);
        chk("start", 32'h1, {31'h0, hit});
        waitc(1, 200);
        chk("capped done", 32'h1, {31'h0, hit});
        rdchk("capped times", OFS_DTIME, 32'h7fff7fff, 32'ha);
        rdchk("nrec", OFS_DSTAT, 32'hfff, 32'h10);
        repeat (100) @(posedge pclk);
        trig_in <= 8'h06;
        waitc(0, 300);
        chk("rearm blocked", 32'h0, {31'h0, hit});
        trig_in <= 8'h00;
        repeat (4) @(posedge pclk);
        trig_in <= 8'h04;
        waitc(0, 300);
        chk("rearm start", 32'h1, {31'h0, hit});
        repeat (24) @(posedge pclk);
        trig_in <= 8'h00;
        waitc(1, 200);
        apb(1'b0, OFS_DTIME, 32'h0);
        chk("event plus tail", 32'd10, 32'(rd[14:0] + rd[30:16]));
        rdchk("used", OFS_DSTORE, 32'h3ffff, 32'd40);
        apb(1'b1, OFS_CTRL, 32'he);
        rdchk("cleared", OFS_DSTORE, 32'h3ffff, 32'h0);
        fault(2, 2, 1'b1);
        chk("notify with store", 32'h1, {31'h0, hit & fault_notify});
        chk("nv meas", 32'h00c0ffee, nv_meas);
        chk("nv info", 32'hd2, {24'h0, nv_info[7:0]});
        rdchk("info same", OFS_FINFO, 32'hff, 32'hd2);
        rdchk("fault no", OFS_FSTAT, 32'hffff, 32'h1);
        rdchk("meas", OFS_FMEAS, 32'hffffffff, 32'h00c0ffee);
        rdchk("ttt ok", OFS_FTTT, 32'h80000000, 32'h80000000);
        apb(1'b1, OFS_FSTAT, 32'h80000000);
        rdchk("notify clear", OFS_FSTAT, 32'h80000000, 32'h0);
        fault(1, 3, 1'b1);
        rdchk("info diff", OFS_FINFO, 32'hff, 32'h8b);
        rdchk("ttt na", OFS_FTTT, 32'h80000000, 32'h0);
        fault(4, 0, 1'b0);
        chk("alarm stored", 32'h1, {31'h0, hit});
        rdchk("no trip flag", OFS_FINFO, 32'h80, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h4);
        fault(5, 0, 1'b0);
        chk("alarm dropped", 32'h0, {31'h0, hit});
        rdchk("count and no", OFS_FSTAT, 32'h801fffff, 32'h80030004);
        apb(1'b1, OFS_MDLY, 32'h5);
        fault(6, 6, 1'b1);
        rdchk("meas delayed", OFS_FMEAS, 32'hffffffff, 32'h0000beef);
        apb(1'b1, OFS_FSEL, 32'h7f);
        rdchk("fsel clamp", OFS_FSEL, 32'h1f, 32'h13);
        apb(1'b1, OFS_FSEL, 32'h3);
        rdchk("oldest no", OFS_FINFO, 32'hffff00, 32'h100);
        end_sim;
    end
endmodule
